// file: ftfc_ctrl.sv
// Summary of operation
// [RL1] Buffer holds sixty-four four-bit words with separate input and output data paths.
// [RL2] Master clear empties the buffer regardless of either port.
// [RL3] Word captured when space flag AND write strobe rises.
// [RL4] Space flag falls to acknowledge a captured word.
// [RL5] Word moves on when strobe and space flag both low; flag rises again.
// [RL6] Words ripple downstream into empty cells faster than external rates.
// [RL7] Word 63 is the output stage, refilled from word 62 when vacated.
// [RL8] Loading the output stage raises the word-available flag.
// [RL9] Word-available falls a fixed delay after it and read strobe are high.
// [RL10] Read strobe falling marks the output stage empty.
// [RL11] Write strobe pulses while space flag is low are ignored.
// [RL12] When full, space flag stays low until space appears downstream.
// [RL13] Reading the only word leaves word-available low, outputs unchanged.
// [RL14] After master clear the space flag goes high.
// [RL15] Controller applies master clear before any write or read.
// [RL16] Width expansion ties strobes and clears together, flags kept separate.
// [RL17] Paralleled units' flags are combined by gates into composite flags.
// [RL18] Depth cascade: word-available drives next write strobe, space flag drives read.
// [RL19] During master clear word-available is low and all cells are empty.
`default_nettype none
module ftfc_ctrl
    import ftfc_pkg::*;
#(
    parameter int unsigned UNITS = 1
) (
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    input  wire logic                          wr_valid,
    output logic                               wr_ready,
    input  wire logic [ftfc_pkg::WORD_W*UNITS-1:0] wr_data,
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output logic      [ftfc_pkg::WORD_W*UNITS-1:0] rd_data,
    output logic                               master_clear_n,
    output logic                               shift_in,
    output logic      [ftfc_pkg::WORD_W*UNITS-1:0] dev_din,
    input  wire logic [UNITS-1:0]              space_flag,
    output logic                               shift_out,
    input  wire logic [UNITS-1:0]              word_avail,
    input  wire logic [ftfc_pkg::WORD_W*UNITS-1:0] dev_dout,
    output logic                               busy
);
    import ftfc_pkg::*;
    localparam int unsigned DW = WORD_W * UNITS;
    if (UNITS < 1 || STROBE_DIV < 1 || STROBE_DIV > (1 << DIV_W) || CLR_CYCLES < 1
        || CLR_CYCLES > (1 << CLR_W)) begin : g_bad_cfg
        $error("ftfc_ctrl: UNITS, STROBE_DIV or CLR_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe pacing divider and clear sequencer
    logic [DIV_W-1:0] div_r;
    logic [CLR_W-1:0] clr_cnt_r;
    logic             clr_done_r;
    wire              tick = (div_r == DIV_W'(STROBE_DIV - 1));
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + 1'b1;
        end
    end
    // Clear is held low for a while before any strobe is issued
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            clr_cnt_r  <= '0;
            clr_done_r <= 1'b0;
        end else if (!clr_done_r) begin // see [RL15]
            clr_cnt_r  <= clr_cnt_r + 1'b1;
            clr_done_r <= (clr_cnt_r == CLR_W'(CLR_CYCLES - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Composite flags across paralleled units
    wire space_all = &space_flag; // see [RL17]
    wire avail_all = &word_avail; // see [RL17]
    wire space_any = |space_flag;
    wire avail_any = |word_avail;

    ////////////////////////////////////////////////////////////////////////////
    // Write side: staging FIFO feeds the device input port
    logic          st_valid;
    logic          st_pop;
    logic [DW-1:0] st_data;
    ftfc_fifo #(.WIDTH(DW), .DEPTH(BUF_DEPTH)) u_stage (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (wr_valid && clr_done_r),
        .in_ready  (),
        .in_data   (wr_data),
        .out_valid (st_valid),
        .out_ready (st_pop),
        .out_data  (st_data)
    );
    ftfc_wr_t wr_st_r;
    ftfc_wr_t wr_st_nxt;
    logic     shift_in_nxt;
    // Strobe only rises while every space flag is high
    wire wr_start = clr_done_r && tick && st_valid && space_all; // see [RL3] [RL11]
    wire wr_acked = !space_any;                                   // see [RL4]
    wire wr_rel   = space_all;                                    // see [RL5] [RL12]
    assign st_pop = (wr_st_r == FTFC_WR_IDLE) && wr_start;
    always_comb begin
        wr_st_nxt    = wr_st_r;
        shift_in_nxt = shift_in;
        unique case (wr_st_r)
            FTFC_WR_IDLE: if (wr_start) begin
                wr_st_nxt    = FTFC_WR_HIGH;
                shift_in_nxt = 1'b1;
            end
            FTFC_WR_HIGH: if (wr_acked && tick) begin
                wr_st_nxt    = FTFC_WR_WAIT;
                shift_in_nxt = 1'b0;
            end
            FTFC_WR_WAIT: if (wr_rel && tick) begin
                wr_st_nxt = FTFC_WR_IDLE;
            end
            default: begin
                wr_st_nxt    = FTFC_WR_IDLE;
                shift_in_nxt = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_st_r       <= FTFC_WR_IDLE;
            shift_in      <= 1'b0;
            dev_din       <= '0;
            wr_ready      <= 1'b0;
        end else begin
            wr_st_r       <= wr_st_nxt;
            shift_in      <= shift_in_nxt;
            wr_ready      <= clr_done_r;
            if (st_pop) dev_din <= st_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read side: take a word when every unit offers one
    ftfc_rd_t      rd_st_r;
    ftfc_rd_t      rd_st_nxt;
    logic          shift_out_nxt;
    logic          rd_take;
    logic [DW-1:0] rd_data_nxt;
    wire rd_free  = !rd_valid || rd_ready;
    wire rd_start = clr_done_r && tick && avail_all && rd_free; // see [RL8]
    assign rd_data_nxt = dev_dout;
    always_comb begin
        rd_st_nxt     = rd_st_r;
        shift_out_nxt = shift_out;
        rd_take       = 1'b0;
        unique case (rd_st_r)
            FTFC_RD_IDLE: if (rd_start) begin
                rd_st_nxt     = FTFC_RD_HIGH;
                shift_out_nxt = 1'b1;
                rd_take       = 1'b1;
            end
            // Hold strobe high until every flag has dropped
            FTFC_RD_HIGH: if (!avail_any && tick) begin // see [RL9] [RL18]
                rd_st_nxt     = FTFC_RD_LOW;
                shift_out_nxt = 1'b0; // see [RL10]
            end
            FTFC_RD_LOW: if (tick) begin
                rd_st_nxt = FTFC_RD_IDLE;
            end
            default: begin
                rd_st_nxt     = FTFC_RD_IDLE;
                shift_out_nxt = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_st_r   <= FTFC_RD_IDLE;
            shift_out <= 1'b0;
            rd_valid  <= 1'b0;
            rd_data   <= '0;
        end else begin
            rd_st_r   <= rd_st_nxt;
            shift_out <= shift_out_nxt;
            if (rd_take) begin
                rd_data  <= rd_data_nxt; // see [RL1]
                rd_valid <= 1'b1;
            end else if (rd_ready) begin
                rd_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear output and status
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            master_clear_n <= 1'b0; // see [RL2] [RL19]
            busy           <= 1'b1;
        end else begin
            master_clear_n <= clr_done_r; // see [RL14] [RL15] [RL16]
            busy           <= !clr_done_r || (wr_st_r != FTFC_WR_IDLE) || st_valid;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wr_raise;
        !shift_in ##1 shift_in;
    endsequence
    property p_strobe_needs_space;
        @(posedge clk_sys) disable iff (sys_rst) s_wr_raise |-> $past(space_all);
    endproperty
    a_strobe_needs_space: assert property (p_strobe_needs_space) else $error("write strobe rose without space"); // see [RL11]
    property p_clear_first;
        @(posedge clk_sys) disable iff (sys_rst) !master_clear_n |-> !shift_in && !shift_out;
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("strobe during master clear"); // see [RL15]
    property p_in_drop_on_ack;
        @(posedge clk_sys) disable iff (sys_rst) $fell(shift_in) |-> $past(!space_any);
    endproperty
    a_in_drop_on_ack: assert property (p_in_drop_on_ack) else $error("write strobe fell before acknowledge"); // see [RL4]
    property p_out_rise_avail;
        @(posedge clk_sys) disable iff (sys_rst) $rose(shift_out) |-> $past(avail_all);
    endproperty
    a_out_rise_avail: assert property (p_out_rise_avail) else $error("read strobe without word available"); // see [RL8]
    property p_out_fall;
        @(posedge clk_sys) disable iff (sys_rst) $fell(shift_out) |-> $past(!avail_any);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("read strobe fell before flag dropped"); // see [RL9]
    property p_take_valid;
        @(posedge clk_sys) disable iff (sys_rst) $rose(shift_out) |-> rd_valid;
    endproperty
    a_take_valid: assert property (p_take_valid) else $error("read word not presented"); // see [RL10]
    property p_clr_release;
        @(posedge clk_sys) disable iff (sys_rst) $rose(master_clear_n) |-> ##[0:0] !shift_in;
    endproperty
    a_clr_release: assert property (p_clr_release) else $error("write strobe at clear release"); // see [RL14]
    property p_din_stable;
        @(posedge clk_sys) disable iff (sys_rst) shift_in && $past(shift_in) |-> $stable(dev_din);
    endproperty
    a_din_stable: assert property (p_din_stable) else $error("input data changed under strobe"); // see [RL3]
endmodule // ftfc_ctrl
`default_nettype wire

// file: ftfc_dev_model.sv
`default_nettype none
module ftfc_dev_model #(
    parameter int unsigned DLY = 2
) (
    input  wire logic                        clk_sys,
    input  wire logic                        master_clear_n,
    input  wire logic                        shift_in,
    input  wire logic [ftfc_pkg::WORD_W-1:0] din,
    input  wire logic                        shift_out,
    output logic                             space_flag,
    output logic                             word_avail,
    output logic      [ftfc_pkg::WORD_W-1:0] dout
);
    timeunit 1ns;
    timeprecision 1ps;
    import ftfc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Cells between input and output stages; with both stages this holds 64 words
    logic [WORD_W-1:0] cells[$];
    logic [WORD_W-1:0] in_word;
    logic              in_full;
    logic              out_full;
    logic              took_d;
    logic              so_d;
    int                in_wait;
    int                out_wait;
    always @(posedge clk_sys or negedge master_clear_n) begin
        if (!master_clear_n) begin
            cells.delete();
            in_full = 1'b0;
            out_full = 1'b0;
            took_d = 1'b0;
            so_d = 1'b0;
            in_wait = 0;
            out_wait = 0;
            space_flag <= 1'b1;
            word_avail <= 1'b0;
        end else begin
            // Capture only on a rising edge of flag AND strobe
            if (space_flag && shift_in && !took_d) begin
                in_word = din;
                in_full = 1'b1;
                space_flag <= 1'b0;
            end
            // Fall-through delay stands for the internal ripple time
            if (in_full && !shift_in && !space_flag && cells.size() < 62) begin
                in_wait++;
                if (in_wait >= DLY) begin
                    cells.push_back(in_word);
                    in_full = 1'b0;
                    in_wait = 0;
                    space_flag <= 1'b1;
                end
            end
            if (!out_full && cells.size() > 0) begin
                out_wait++;
                if (out_wait >= DLY) begin
                    dout <= cells.pop_front();
                    out_full = 1'b1;
                    out_wait = 0;
                    word_avail <= 1'b1;
                end
            end
            if (word_avail && shift_out) begin
                word_avail <= 1'b0;
            end
            if (so_d && !shift_out) begin
                out_full = 1'b0;
            end
            took_d = space_flag && shift_in;
            so_d = shift_out;
        end
    end
endmodule // ftfc_dev_model
`default_nettype wire

// file: ftfc_fifo.sv
`default_nettype none
module ftfc_fifo #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("ftfc_fifo: DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    wire              full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire              empty = (wp_r == rp_r);
    wire              push  = in_valid && !full;
    wire              pop   = out_ready && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop)  rp_r <= rp_r + 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (push) mem_r[wp_r[AW-1:0]] <= in_data;
    end
endmodule // ftfc_fifo
`default_nettype wire

// file: ftfc_pkg.sv
`default_nettype none
package ftfc_pkg;
    localparam int unsigned WORD_W      = 4;
    localparam int unsigned BUF_DEPTH   = 8;
    localparam int unsigned CLR_CYCLES  = 4;
    localparam int unsigned STROBE_DIV  = 2;
    localparam int unsigned DIV_W       = 4;
    localparam int unsigned CLR_W       = 4;
    typedef enum logic [1:0] {FTFC_WR_IDLE, FTFC_WR_HIGH, FTFC_WR_WAIT} ftfc_wr_t;
    typedef enum logic [1:0] {FTFC_RD_IDLE, FTFC_RD_HIGH, FTFC_RD_LOW} ftfc_rd_t;
endpackage
`default_nettype wire

// file: ftfc_tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ftfc_pkg::*;
    logic       clk_sys, sys_rst, wr_valid, wr_ready, rd_valid, rd_ready, master_clear_n;
    logic       shift_in, shift_out, busy;
    logic [7:0] wr_data, rd_data, dev_din, dev_dout;
    logic [1:0] space_flag, word_avail;
    int         fails, checks, wr_idx, rd_idx;
    ftfc_ctrl #(.UNITS(2)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .master_clear_n(master_clear_n), .shift_in(shift_in), .dev_din(dev_din), .space_flag(space_flag),
        .shift_out(shift_out), .word_avail(word_avail), .dev_dout(dev_dout), .busy(busy));
    // Two units with unequal fall-through times
    for (genvar k = 0; k < 2; k++) begin : g_unit
        ftfc_dev_model #(.DLY(1 + 2 * k)) u_dev (.clk_sys(clk_sys), .master_clear_n(master_clear_n),
            .shift_in(shift_in), .din(dev_din[4*k+:4]), .shift_out(shift_out),
            .space_flag(space_flag[k]), .word_avail(word_avail[k]), .dout(dev_dout[4*k+:4]));
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(int i);
        return 8'(i * 37 + 5);
    endfunction
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic put(bit wait_idle);
        int n = 0;
        while (wait_idle && busy !== 1'b0 && n < 500) begin
            tick(1);
            n++;
        end
        if (wait_idle) chk("busy", 8'h0, {7'h0, busy});
        wr_data = pat(wr_idx);
        wr_valid = 1'b1;
        wr_idx++;
        tick(1);
        wr_valid = 1'b0;
        tick(1);
    endtask
    task automatic get();
        int n = 0;
        while (rd_valid !== 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
        chk("rd_valid", 8'h1, {7'h0, rd_valid});
        chk("rd_data", pat(rd_idx), rd_data);
        rd_idx++;
        rd_ready = 1'b1;
        tick(1);
        rd_ready = 1'b0;
        tick(1);
    endtask
    task automatic wait_up();
        int n = 0;
        while (wr_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk("wr_ready", 8'h1, {7'h0, wr_ready});
        chk("space_flag", 8'h3, {6'h0, space_flag});
        chk("word_avail", 8'h0, {6'h0, word_avail});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_single();
        int n = 0;
        put(1'b1);
        while (shift_in !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("dev_din", pat(wr_idx - 1), dev_din);
        n = 0;
        while (rd_valid !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk("shift_out", 8'h1, {7'h0, shift_out});
        get();
        tick(20);
        chk("rd_valid idle", 8'h0, {7'h0, rd_valid});
        chk("avail idle", 8'h0, {6'h0, word_avail});
        chk("dout held", pat(rd_idx - 1), dev_dout);
    endtask
    task automatic t_stream();
        fork
            repeat (20) put(1'b1);
            repeat (20) get();
        join
    endtask
    task automatic t_fill();
        repeat (65) put(1'b1);
        put(1'b0);
        tick(60);
        chk("busy full", 8'h1, {7'h0, busy});
        chk("space full", 8'h0, {6'h0, space_flag});
        chk("shift_in full", 8'h0, {7'h0, shift_in});
        repeat (66) get();
    endtask
    task automatic t_clear();
        repeat (3) put(1'b1);
        tick(20);
        sys_rst = 1'b1;
        tick(2);
        chk("clear_n", 8'h0, {7'h0, master_clear_n});
        chk("avail clear", 8'h0, {6'h0, word_avail});
        chk("wr_ready clear", 8'h0, {7'h0, wr_ready});
        sys_rst = 1'b0;
        wait_up();
        tick(30);
        chk("rd_valid clear", 8'h0, {7'h0, rd_valid});
        rd_idx = wr_idx;
        put(1'b1);
        get();
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        rd_ready = 1'b0;
        tick(16);
        chk("clear_n rst", 8'h0, {7'h0, master_clear_n});
        sys_rst = 1'b0;
        wait_up();
        t_single();
        t_stream();
        t_fill();
        t_clear();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
